// ---- hw/interrupt_enable_priority_low.sv ----
// Second interrupt enable and first low priority registers with request gating
`timescale 1ns/100ps
module interrupt_enable_priority_low (
    input wire logic clock,
    input wire logic rst,
    input wire logic clockEn,
    input irq_regs_pkg::apb_req_t apbReq,
    output irq_regs_pkg::apb_rsp_t apbRsp,
    input wire logic [irq_regs_pkg::N_EN_SRC-1:0] enGroupReq,
    input wire logic [irq_regs_pkg::N_EN_SRC-1:0][1:0] enGroupLevel,
    input wire logic [irq_regs_pkg::N_PR_SRC-1:0] prGroupReq,
    input wire logic [irq_regs_pkg::N_PR_SRC-1:0] prGroupEnable,
    output logic [irq_regs_pkg::N_EN_SRC-1:0] enGroupFwd,
    output logic [irq_regs_pkg::N_PR_SRC-1:0] prGroupFwd,
    output irq_regs_pkg::prio_level_t [irq_regs_pkg::N_PR_SRC-1:0] prGroupLevel
);
    import irq_regs_pkg::*;

    logic [REG_W-1:0] enableSecond_r; // Second enable register
    logic [REG_W-1:0] prioLowFirst_r; // First low priority register
    logic [REG_W-1:0] prioHighFirst_r; // High priority companion
    logic [REG_W-1:0] globalCtrl_r; // Global enable register
    logic [DATA_W-1:0] rdata_r; // Read data held for the access phase
    logic [DATA_W-1:0] rdataNxt; // Read data selected by address
    logic slvErr_r; // Unmapped address flag for the access phase
    logic hit; // Address matches a register
    logic setupPhase; // First cycle of a transfer
    logic wrStrobe; // Write takes effect this edge
    logic globalEn; // Global enable bit
    logic [N_SRC-1:0] srcReq; // Combined requests
    logic [N_SRC-1:0] srcEn; // Combined enables
    logic [N_SRC-1:0] srcHigh; // Combined high priority bits
    logic [N_SRC-1:0] srcLow; // Combined low priority bits
    logic [N_SRC-1:0] srcFwd; // Combined forwarded requests
    logic [N_SRC-1:0][1:0] srcLevel; // Combined levels

    // Bus phase decode, writes only land while the clock enable is high
    assign setupPhase = apbReq.psel && !apbReq.penable;
    assign wrStrobe = clockEn && apbReq.psel && apbReq.penable && apbReq.pwrite;
    assign globalEn = globalCtrl_r[BIT_GLOBAL_EN];

    // Address decode and read mux
    always_comb begin
        hit = 1'b1;
        rdataNxt = '0;
        case (apbReq.paddr)
            ADR_ENABLE_SECOND: rdataNxt[REG_W-1:0] = enableSecond_r;
            ADR_PRIO_LOW_FIRST: rdataNxt[REG_W-1:0] = prioLowFirst_r;
            ADR_PRIO_HIGH_FIRST: rdataNxt[REG_W-1:0] = prioHighFirst_r;
            ADR_GLOBAL_CTRL: rdataNxt[REG_W-1:0] = globalCtrl_r;
            default: hit = 1'b0; // Unmapped reads as zero with error
        endcase
    end

    // Read data and error captured in the setup cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_r <= '0;
            slvErr_r <= 1'b0;
        end else if (clockEn && setupPhase) begin
            rdata_r <= apbReq.pwrite ? '0 : rdataNxt;
            slvErr_r <= !hit;
        end
    end

    // Zero wait answer, stalled by the clock enable
    assign apbRsp.pready = clockEn;
    assign apbRsp.pslverr = slvErr_r && apbReq.psel && apbReq.penable;
    assign apbRsp.prdata = rdata_r;

    // Second enable register, reserved bits held at zero
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            enableSecond_r <= RST_REG;
        end else if (wrStrobe && apbReq.paddr == ADR_ENABLE_SECOND) begin
            enableSecond_r <= apbReq.pwdata[REG_W-1:0] & MASK_ENABLE_SECOND;
        end
    end

    // First low priority register, all bits writable
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prioLowFirst_r <= RST_REG;
        end else if (wrStrobe && apbReq.paddr == ADR_PRIO_LOW_FIRST) begin
            prioLowFirst_r <= apbReq.pwdata[REG_W-1:0];
        end
    end

    // High priority companion register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prioHighFirst_r <= RST_REG;
        end else if (wrStrobe && apbReq.paddr == ADR_PRIO_HIGH_FIRST) begin
            prioHighFirst_r <= apbReq.pwdata[REG_W-1:0];
        end
    end

    // Global control register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            globalCtrl_r <= RST_REG;
        end else if (wrStrobe && apbReq.paddr == ADR_GLOBAL_CTRL) begin
            globalCtrl_r <= apbReq.pwdata[REG_W-1:0] & MASK_GLOBAL_CTRL;
        end
    end

    // Enable group slots 4..0: ADC, comparator, SPI, two-wire, keyboard
    // Each slot takes its own enable bit, so no slot overlaps the priority group
    assign srcReq[N_EN_SRC-1:0] = enGroupReq;
    assign srcEn[SRC_ADC] = enableSecond_r[BIT_ADC_EN];
    assign srcEn[SRC_CMP] = enableSecond_r[BIT_CMP_EN];
    assign srcEn[SRC_SPI] = enableSecond_r[BIT_SPI_EN];
    assign srcEn[SRC_TWI] = enableSecond_r[BIT_TWI_EN];
    assign srcEn[SRC_KBD] = enableSecond_r[BIT_KBD_EN];
    // Reserved bits 7, 6 and 3 gate nothing

    // Priority group: index 6 is counter array, 5..0 timer2 to ext0
    assign srcReq[N_SRC-1:N_EN_SRC] = prGroupReq;
    assign srcEn[N_SRC-1:N_EN_SRC] = prGroupEnable;
    assign srcLow[N_SRC-1:N_EN_SRC] = prioLowFirst_r[BIT_PCA_PRIO:0];
    assign srcHigh[N_SRC-1:N_EN_SRC] = prioHighFirst_r[BIT_PCA_PRIO:0];

    // Enable group levels come from registers outside this block
    genvar g;
    generate
        for (g = 0; g < N_SRC; g++) begin : gSrc
            if (g < N_EN_SRC) begin : gLvl
                assign srcHigh[g] = enGroupLevel[g][1];
                assign srcLow[g] = enGroupLevel[g][0];
            end
            irq_gate_cell uCell (
                .clock(clock),
                .rst(rst),
                .clockEn(clockEn),
                .req(srcReq[g]),
                .srcEnable(srcEn[g]),
                .globalEn(globalEn),
                .prioHigh(srcHigh[g]),
                .prioLow(srcLow[g]),
                .disLevel0(prioLowFirst_r[BIT_LEVEL0_DIS]),
                .disLevel1(prioHighFirst_r[BIT_LEVEL1_DIS]),
                .fwd(srcFwd[g]),
                .level(srcLevel[g])
            );
        end
    endgenerate

    // Split the combined vectors back to the group outputs
    assign enGroupFwd = srcFwd[N_EN_SRC-1:0];
    assign prGroupFwd = srcFwd[N_SRC-1:N_EN_SRC];
    assign prGroupLevel = srcLevel[N_SRC-1:N_EN_SRC];

    // Checks run on the core clock and stay quiet during reset
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // ADC request gated by its enable and the global enable
    a_adc_gate: assert property ($past(clockEn) && $past(srcFwd[SRC_ADC] == 1'b0) ##0
        $past(enGroupReq[SRC_ADC] && enableSecond_r[BIT_ADC_EN] && globalEn
        && !prioLowFirst_r[BIT_LEVEL0_DIS] && enGroupLevel[SRC_ADC] == 2'h0)
        |-> enGroupFwd[SRC_ADC]) else $error("ADC request not forwarded");
    // SPI enable clear blocks SPI
    a_spi_gate: assert property ($past(clockEn) && !$past(enableSecond_r[BIT_SPI_EN])
        |-> !enGroupFwd[SRC_SPI]) else $error("SPI forwarded while disabled");
    // Two-wire enable clear blocks two-wire
    a_twi_gate: assert property ($past(clockEn) && !$past(enableSecond_r[BIT_TWI_EN])
        |-> !enGroupFwd[SRC_TWI]) else $error("Two-wire forwarded while disabled");
    // Keyboard forwarded after two enabled cycles of request
    a_kbd_pass: assert property ((clockEn && enGroupReq[SRC_KBD]
        && enableSecond_r[BIT_KBD_EN] && globalEn && !prioLowFirst_r[BIT_LEVEL0_DIS]
        && enGroupLevel[SRC_KBD] == 2'h0) [*2]
        |=> enGroupFwd[SRC_KBD]) else $error("Keyboard request not forwarded");
    // Priority source 0 silent at level 0 while level 0 disabled
    a_lvl0_block: assert property ($past(clockEn) && $past(prioLowFirst_r[BIT_LEVEL0_DIS])
        && $past(prioHighFirst_r[0] == 1'b0 && prioLowFirst_r[0] == 1'b0)
        |-> !prGroupFwd[0]) else $error("Level 0 source forwarded while disabled");
    // Counter array level low bit follows bit 6
    a_pca_level: assert property ($past(clockEn)
        |-> prGroupLevel[N_PR_SRC-1][0] == $past(prioLowFirst_r[BIT_PCA_PRIO]))
        else $error("Counter array level low bit wrong");
    // Registers read zero right after reset
    a_reset_zero: assert property ($fell(rst) |-> enableSecond_r == 8'h00
        && prioLowFirst_r == 8'h00) else $error("Register not zero after reset");
    // Timer2 and ext0 levels follow bits 5 and 0
    a_low_bits: assert property ($past(clockEn)
        |-> prGroupLevel[5] == {$past(prioHighFirst_r[5]), $past(prioLowFirst_r[5])}
        && prGroupLevel[0] == {$past(prioHighFirst_r[0]), $past(prioLowFirst_r[0])})
        else $error("Priority level bits misplaced");
    // Global enable clear blocks all sources
    a_global_off: assert property ($past(clockEn) && !$past(globalEn)
        |-> srcFwd == '0) else $error("Source forwarded with global enable clear");
    // Write lands in the second enable register with reserved bits masked
    a_enable_write: assert property (wrStrobe && apbReq.paddr == ADR_ENABLE_SECOND
        |=> enableSecond_r == ($past(apbReq.pwdata[7:0]) & 8'h37))
        else $error("Second enable write wrong");
    // ADC enable clear blocks ADC
    a_adc_block: assert property ($past(clockEn) && !$past(enableSecond_r[BIT_ADC_EN])
        |-> !enGroupFwd[SRC_ADC]) else $error("ADC forwarded while disabled");
    // Keyboard enable clear blocks keyboard
    a_kbd_block: assert property ($past(clockEn) && !$past(enableSecond_r[BIT_KBD_EN])
        |-> !enGroupFwd[SRC_KBD]) else $error("Keyboard forwarded while disabled");
    // Comparator enable clear blocks comparator
    a_cmp_gate: assert property ($past(clockEn) && !$past(enableSecond_r[BIT_CMP_EN])
        |-> !enGroupFwd[SRC_CMP]) else $error("Comparator forwarded while disabled");
    // Level 0 source passes while level 0 is allowed
    a_lvl0_allow: assert property ($past(clockEn) && $past(prGroupReq[0]
        && prGroupEnable[0] && globalEn && !prioLowFirst_r[BIT_LEVEL0_DIS]
        && prioHighFirst_r[0] == 1'b0 && prioLowFirst_r[0] == 1'b0)
        |-> prGroupFwd[0]) else $error("Level 0 source held while allowed");
    // Priority source 0 silent at level 1 while level 1 disabled
    a_lvl1_block: assert property ($past(clockEn) && $past(prioHighFirst_r[BIT_LEVEL1_DIS])
        && $past(prioHighFirst_r[0] == 1'b0 && prioLowFirst_r[0] == 1'b1)
        |-> !prGroupFwd[0]) else $error("Level 1 source forwarded while disabled");
    // Clock enable low freezes forwarded requests and levels
    a_hold_fwd: assert property (!$past(clockEn) |-> $stable(srcFwd) && $stable(srcLevel))
        else $error("Forwarded request moved while frozen");
    // Clock enable low freezes the registers
    a_hold_regs: assert property (!$past(clockEn) |-> $stable(enableSecond_r)
        && $stable(prioLowFirst_r)) else $error("Register moved while frozen");
    // Unmapped access answers with zero data
    a_err_data: assert property (apbRsp.pslverr |-> apbRsp.prdata == '0)
        else $error("Unmapped access returned data");
endmodule : interrupt_enable_priority_low

// ---- hw/irq_gate_cell.sv ----
// One interrupt source gate with priority level and level suppression
`timescale 1ns/100ps
module irq_gate_cell (
    input wire logic clock,
    input wire logic rst,
    input wire logic clockEn,
    input wire logic req,
    input wire logic srcEnable,
    input wire logic globalEn,
    input wire logic prioHigh,
    input wire logic prioLow,
    input wire logic disLevel0,
    input wire logic disLevel1,
    output logic fwd,
    output logic [1:0] level
);
    logic [1:0] levelNxt; // Resolved level of this source
    logic blocked; // Level is currently switched off

    // Combine high and low priority bits
    assign levelNxt = {prioHigh, prioLow};
    // Disable bits for levels 0 and 1
    assign blocked = ((levelNxt == 2'h0) && disLevel0)
        || ((levelNxt == 2'h1) && disLevel1);

    // Registered forwarded request
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fwd <= 1'b0;
        end else if (clockEn) begin
            fwd <= req && srcEnable && globalEn && !blocked;
        end
    end

    // Registered priority level
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            level <= 2'h0;
        end else if (clockEn) begin
            level <= levelNxt;
        end
    end
endmodule : irq_gate_cell

// ---- inc/irq_regs_pkg.sv ----
// Constants and carrier types for the interrupt enable and low priority registers
// What this block does
// - ADC request needs its enable and global enable
// - Two-wire request needs its enable and global enable
// - Keyboard request needs its enable and global enable
// - Level 0 disable bit suppresses level 0
// - Bit 6 is counter array priority low
// - Both registers reset to all zeros
// - Global enable clear blocks every source
// - Priority level is high bit with low bit
package irq_regs_pkg;
    localparam int ADDR_W = 12; // APB byte address width
    localparam int DATA_W = 32; // APB data width
    localparam int REG_W = 8; // Register width
    localparam int N_EN_SRC = 5; // Sources gated by the second enable register
    localparam int N_PR_SRC = 7; // Sources ranked by the first low priority register
    localparam int N_SRC = N_EN_SRC + N_PR_SRC; // All sources handled here
    // Register indices, byte address is four times the index
    localparam logic [7:0] IDX_ENABLE_SECOND = 8'hb1;
    localparam logic [7:0] IDX_PRIO_LOW_FIRST = 8'hb8;
    localparam logic [7:0] IDX_PRIO_HIGH_FIRST = 8'hb7;
    localparam logic [7:0] IDX_GLOBAL_CTRL = 8'ha8;
    localparam logic [ADDR_W-1:0] ADR_ENABLE_SECOND = {2'h0, IDX_ENABLE_SECOND, 2'h0};
    localparam logic [ADDR_W-1:0] ADR_PRIO_LOW_FIRST = {2'h0, IDX_PRIO_LOW_FIRST, 2'h0};
    localparam logic [ADDR_W-1:0] ADR_PRIO_HIGH_FIRST = {2'h0, IDX_PRIO_HIGH_FIRST, 2'h0};
    localparam logic [ADDR_W-1:0] ADR_GLOBAL_CTRL = {2'h0, IDX_GLOBAL_CTRL, 2'h0};
    // Second enable register fields
    localparam int BIT_ADC_EN = 5;
    localparam int BIT_CMP_EN = 4;
    localparam int BIT_SPI_EN = 2;
    localparam int BIT_TWI_EN = 1;
    localparam int BIT_KBD_EN = 0;
    localparam logic [REG_W-1:0] MASK_ENABLE_SECOND = 8'h37; // Bits 7, 6, 3 reserved
    // Priority register fields
    localparam int BIT_LEVEL0_DIS = 7; // In the low priority register
    localparam int BIT_LEVEL1_DIS = 7; // In the high priority register
    localparam int BIT_PCA_PRIO = 6; // Counter array priority bit
    // Global control field
    localparam int BIT_GLOBAL_EN = 7;
    localparam logic [REG_W-1:0] MASK_GLOBAL_CTRL = 8'h80;
    // Reset values
    localparam logic [REG_W-1:0] RST_REG = 8'h00;
    // Source index of the enable group within the combined vector
    localparam int SRC_KBD = 0;
    localparam int SRC_TWI = 1;
    localparam int SRC_SPI = 2;
    localparam int SRC_CMP = 3;
    localparam int SRC_ADC = 4;

    // APB request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } apb_req_t;

    // APB answer to the master
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [DATA_W-1:0] prdata;
    } apb_rsp_t;

    // Two-bit priority level per source
    typedef logic [1:0] prio_level_t;
endpackage : irq_regs_pkg

// ---- verif/irq_source_model.sv ----
// Peripheral request sources and level inputs facing the gating block
`timescale 1ns/100ps
module irq_source_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic [4:0] enCmd,
    input wire logic [9:0] lvlCmd,
    input wire logic [6:0] prCmd,
    input wire logic [6:0] prEnCmd,
    output logic [4:0] enReq,
    output logic [9:0] enLvl,
    output logic [6:0] prReq,
    output logic [6:0] prEn
);
    // Requests are held levels, raised one edge after the command, cleared on reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            {enReq, enLvl, prReq, prEn} <= '0;
        end else begin
            {enReq, enLvl, prReq, prEn} <= {enCmd, lvlCmd, prCmd, prEnCmd};
        end
    end
endmodule : irq_source_model

// ---- verif/test_interrupt_enable_priority_low.sv ----
// Self-checking bench for the enable and low priority register block
`timescale 1ns/100ps
module test_interrupt_enable_priority_low;
    import irq_regs_pkg::*;
    // One gating case: register values, requests, expected outputs
    typedef struct packed {
        logic [7:0] glob, ien, ipl, iph;
        logic [4:0] enReq;
        logic [9:0] enLvl;
        logic [6:0] prReq, prEn;
        logic [4:0] expEn;
        logic [6:0] expPr;
        logic [13:0] expLvl;
    } row_t;
    // Global off, all on, partial enables, level 0 off, level 1 off, mixed levels
    row_t rows [7] = '{
        '{8'h00, 8'h37, 8'h00, 8'h00, 5'h1f, 10'h000, 7'h7f, 7'h7f, 5'h00, 7'h00, 14'h0000},
        '{8'h80, 8'h37, 8'h00, 8'h00, 5'h1f, 10'h000, 7'h7f, 7'h7f, 5'h1f, 7'h7f, 14'h0000},
        '{8'h80, 8'h05, 8'h00, 8'h00, 5'h1f, 10'h000, 7'h7f, 7'h55, 5'h05, 7'h55, 14'h0000},
        '{8'h80, 8'h37, 8'h80, 8'h00, 5'h1f, 10'h000, 7'h7f, 7'h7f, 5'h00, 7'h00, 14'h0000},
        '{8'h80, 8'h37, 8'hc3, 8'h00, 5'h1f, 10'h001, 7'h7f, 7'h7f, 5'h01, 7'h43, 14'h1005},
        '{8'h80, 8'h37, 8'h3f, 8'hc0, 5'h1f, 10'h2aa, 7'h7f, 7'h7f, 5'h1f, 7'h40, 14'h2555},
        '{8'h80, 8'h02, 8'h2a, 8'h15, 5'h1f, 10'h000, 7'h7f, 7'h7f, 5'h02, 7'h7f, 14'h0666}
    };
    logic clock, rst, clockEn; // Clock, reset, run enable
    apb_req_t apbReq; // Bus request
    apb_rsp_t apbRsp; // Bus answer
    logic [4:0] enCmd, enReq, enFwd; // Enable group
    logic [9:0] lvlCmd, enLvl; // Enable group levels
    logic [6:0] prCmd, prEnCmd, prReq, prEn, prFwd; // Priority group
    prio_level_t [6:0] prLvl; // Resolved levels
    int nFail = 0, nTests = 0, cycles = 0; // Counters
    irq_source_model irq_source_model_inst (.clock(clock), .rst(rst), .enCmd(enCmd),
        .lvlCmd(lvlCmd), .prCmd(prCmd), .prEnCmd(prEnCmd), .enReq(enReq), .enLvl(enLvl),
        .prReq(prReq), .prEn(prEn));
    interrupt_enable_priority_low interrupt_enable_priority_low_inst (.clock(clock),
        .rst(rst), .clockEn(clockEn), .apbReq(apbReq), .apbRsp(apbRsp), .enGroupReq(enReq),
        .enGroupLevel(enLvl), .prGroupReq(prReq), .prGroupEnable(prEn), .enGroupFwd(enFwd),
        .prGroupFwd(prFwd), .prGroupLevel(prLvl));
    // Clock of 10 ns period
    always #5 clock = ~clock;
    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 1000) begin
            nFail++;
            final_report();
        end
    end
    // Compare and count
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            nFail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // One bus transfer: setup, then access until ready
    task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d,
            output logic [31:0] rd, output logic err);
        @(posedge clock);
        apbReq <= '{1'b1, 1'b0, w, a, {24'h0, d}};
        @(posedge clock);
        apbReq.penable <= 1'b1;
        do @(posedge clock); while (apbRsp.pready !== 1'b1);
        rd = apbRsp.prdata;
        err = apbRsp.pslverr;
        apbReq <= '0;
    endtask : apb
    // Counts, verdict, end of run
    task final_report();
        $display("checks %0d mismatches %0d", nTests, nFail);
        if (nFail == 0 && nTests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report
    // Main sequence
    initial begin
        row_t r;
        logic [31:0] rd;
        logic err;
        clock = 0;
        rst = 1;
        clockEn = 1;
        apbReq = '0;
        {enCmd, lvlCmd, prCmd, prEnCmd} = '0;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        // Table of gating cases
        foreach (rows[i]) begin
            r = rows[i];
            apb(1'b1, ADR_GLOBAL_CTRL, r.glob, rd, err);
            apb(1'b1, ADR_ENABLE_SECOND, r.ien, rd, err);
            apb(1'b1, ADR_PRIO_LOW_FIRST, r.ipl, rd, err);
            apb(1'b1, ADR_PRIO_HIGH_FIRST, r.iph, rd, err);
            @(posedge clock);
            {enCmd, lvlCmd, prCmd, prEnCmd} <= {r.enReq, r.enLvl, r.prReq, r.prEn};
            repeat (4) @(posedge clock);
            @(negedge clock);
            check("enable fwd", {27'h0, enFwd}, {27'h0, r.expEn});
            check("prio fwd", {25'h0, prFwd}, {25'h0, r.expPr});
            check("prio level", {18'h0, prLvl}, {18'h0, r.expLvl});
        end
        // Reserved bits of the enable register stay zero
        apb(1'b1, ADR_ENABLE_SECOND, 8'hff, rd, err);
        apb(1'b0, ADR_ENABLE_SECOND, 8'h00, rd, err);
        check("enable readback", rd, 32'h37);
        apb(1'b0, ADR_PRIO_LOW_FIRST, 8'h00, rd, err);
        check("prio readback", rd, 32'h2a);
        // Unmapped address is refused
        apb(1'b1, 12'h004, 8'h5a, rd, err);
        check("unmapped err", {31'h0, err}, 32'h1);
        apb(1'b0, 12'h004, 8'h00, rd, err);
        check("unmapped data", rd, 32'h0);
        // Clock enable low freezes forwarding and drops ready
        @(posedge clock);
        clockEn <= 1'b0;
        enCmd <= 5'h00;
        repeat (3) @(posedge clock);
        @(negedge clock);
        check("frozen fwd", {27'h0, enFwd}, 32'h1f);
        check("stalled ready", {31'h0, apbRsp.pready}, 32'h0);
        @(posedge clock);
        clockEn <= 1'b1;
        repeat (2) @(posedge clock);
        @(negedge clock);
        check("released fwd", {27'h0, enFwd}, 32'h0);
        // Reset in mid-run clears both registers and outputs
        @(posedge clock);
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        apb(1'b0, ADR_ENABLE_SECOND, 8'h00, rd, err);
        check("enable reset", rd, 32'h0);
        apb(1'b0, ADR_PRIO_LOW_FIRST, 8'h00, rd, err);
        check("prio reset", rd, 32'h0);
        check("level reset", {18'h0, prLvl}, 32'h0);
        final_report();
    end
endmodule : test_interrupt_enable_priority_low
